/* File: design/bus_term_pkg.sv */
package bus_term_pkg;

  // Bus monitor window and derived cycle count at 50 MHz.
  localparam int unsigned CLK_PERIOD_NS     = 20;
  localparam int unsigned MONITOR_WINDOW_NS = 20480;
  localparam int unsigned MONITOR_CYCLES    =
    MONITOR_WINDOW_NS / CLK_PERIOD_NS;
  localparam int unsigned MON_W             = 11;

  // Speaker tone divider: half period in clock cycles.
  localparam int unsigned SPK_HALF_CYCLES   = 25000;
  localparam int unsigned SPK_W             = 15;

  // Pin function selections for shared pins.
  localparam logic [1:0] KILL_FN_KILL    = 2'h0;
  localparam logic [1:0] KILL_FN_RETRY   = 2'h1;
  localparam logic [1:0] KILL_FN_IRQ     = 2'h2;
  localparam logic [1:0] KILL_FN_SPEAKER = 2'h3;

  // Owner of the current slave access.
  localparam logic [1:0] OWN_EXTERNAL  = 2'h0;
  localparam logic [1:0] OWN_MEMCTL    = 2'h1;
  localparam logic [1:0] OWN_CARD      = 2'h2;
  localparam logic [1:0] OWN_CHIPSEL   = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_END   = 2'b10,
    ST_RETRY = 2'b11
  } bus_state_t;

endpackage

/* File: design/pin_sync.sv */
`timescale 1ns/10ps
// Three-stage synchroniser; output changes once stages two and three agree.
module pin_sync #(
  parameter int unsigned WIDTH = 4
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  // Data
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinOut
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] out_next;

  always_comb begin
    out_next = out_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        out_next[i] = s3_reg[i];
      end
    end
  end

  // Lines idle high, so reset to ones.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s1_reg  <= '1;
      s2_reg  <= '1;
      s3_reg  <= '1;
      out_reg <= '1;
    end else begin
      s1_reg  <= pinIn;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign pinOut = out_reg;

endmodule

/* File: design/bus_termination_reservation.sv */
`timescale 1ns/10ps
// Function
// R1: Addressed slave asserts acknowledge after accepting write or driving read data.
// R2: Device drives acknowledge when memory or card controller owns the access.
// R3: Chip-select access with external acknowledge option waits for slave.
// R4: Any acknowledge driver negates it at end, then releases immediately.
// R5: Bus monitor asserts transfer error when no termination within window.
// R6: Transfer error ends the cycle as bus error, ignoring acknowledge.
// R7: Non-burst slave asserts burst inhibit when addressed by a burst.
// R8: Device drives burst inhibit when card or memory controller owns access.
// R9: Reservation output goes with address for reserve or conditional store.
// R10: Kill-reservation input during conditional store clears the reservation.
// R11: Retry makes device drop mastership and rerun the same transaction.
// R12: Cancel-reservation input clears a held reservation.
// R13: Interrupt four is AND of kill pin and parity lane one.
// R14: Interrupt three is AND of cancel pin and parity lane zero.
// R15: Reservation pin as interrupt two feeds the interrupt controller.
// R16: Kill pin in speaker mode drives an audio square wave.
// R17: All these lines are active low, sampled on the bus clock.
module bus_termination_reservation (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // Pin function configuration
  input  wire logic [1:0] killPinFn,
  input  wire logic       cancelPinIsIrq,
  input  wire logic       resvPinIsIrq,
  input  wire logic       parityZeroIsIrq,
  input  wire logic       parityOneIsIrq,
  input  wire logic       chipSelExtAck,
  // Internal master transaction request
  input  wire logic       txStart,
  input  wire logic       txReserve,
  input  wire logic       txCondStore,
  input  wire logic       txBurst,
  input  wire logic       txBusGrant,
  output logic            txDone,
  output logic            txError,
  output logic            txRetry,
  output logic            txBurstDenied,
  output logic            busRelease,
  // Slave access owned by internal controllers
  input  wire logic [1:0] accessOwner,
  input  wire logic       ctlAckReq,
  input  wire logic       ctlBurstInhibit,
  // Reservation state
  output logic            reservationHeld,
  output logic            reservationLost,
  // Interrupt requests to the interrupt controller
  output logic            irqTwoReq,
  output logic            irqThreeReq,
  output logic            irqFourReq,
  // Transfer acknowledge pin
  input  wire logic       transfer_ack_n_in,
  output logic            transfer_ack_n_out,
  output logic            transfer_ack_n_oe_n,
  // Transfer error acknowledge pin, open drain
  input  wire logic       transfer_error_ack_n_in,
  output logic            transfer_error_ack_n_out,
  output logic            transfer_error_ack_n_oe_n,
  // Burst inhibit pin
  input  wire logic       burst_inhibit_n_in,
  output logic            burst_inhibit_n_out,
  output logic            burst_inhibit_n_oe_n,
  // Reservation pin
  input  wire logic       reservation_out_n_in,
  output logic            reservation_out_n_out,
  output logic            reservation_out_n_oe_n,
  // Kill reservation, retry and speaker pin
  input  wire logic       kill_reservation_n_in,
  output logic            speaker_wave_out,
  output logic            kill_reservation_n_oe_n,
  // Cancel reservation and parity lane pins
  input  wire logic       cancel_reservation_n,
  input  wire logic       parity_lane_zero,
  input  wire logic       parity_lane_one
);

  ////////////////////////////////////////////////////////////////////////////
  logic [6:0] pinSync;

  // Every pin from outside except parity lane zero, which has its own three stages below, passes the three-stage synchroniser.
  pin_sync #(
    .WIDTH (7)
  ) u_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .pinIn   ({transfer_ack_n_in, transfer_error_ack_n_in,
               burst_inhibit_n_in, reservation_out_n_in,
               kill_reservation_n_in, cancel_reservation_n,
               parity_lane_one}),
    .pinOut  (pinSync)
  ); // R17

  logic ackLow;
  logic errLow;
  logic inhibitLow;
  logic resvPinLow;
  logic killLow;
  logic cancelLow;
  logic parOne;
  logic parZero;
  logic parZero1_reg;
  logic parZero2_reg;
  logic parZero3_reg;
  logic parZero_reg;
  logic parZero_next;

  assign ackLow     = !pinSync[6]; // R17
  assign errLow     = !pinSync[5]; // R17
  assign inhibitLow = !pinSync[4];
  assign resvPinLow = !pinSync[3];
  assign killLow    = !pinSync[2];
  assign cancelLow  = !pinSync[1];
  assign parOne     = pinSync[0];
  assign parZero    = parZero_reg;

  always_comb begin
    parZero_next = parZero_reg;
    if (parZero2_reg == parZero3_reg) begin
      parZero_next = parZero3_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      parZero1_reg <= 1'b1;
      parZero2_reg <= 1'b1;
      parZero3_reg <= 1'b1;
      parZero_reg  <= 1'b1;
    end else begin
      parZero1_reg <= parity_lane_zero;
      parZero2_reg <= parZero1_reg;
      parZero3_reg <= parZero2_reg;
      parZero_reg  <= parZero_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer state machine for internally mastered cycles.
  bus_term_pkg::bus_state_t state_reg;
  bus_term_pkg::bus_state_t state_next;
  logic [bus_term_pkg::MON_W-1:0] mon_reg;
  logic [bus_term_pkg::MON_W-1:0] mon_next;
  logic resvTx_reg;
  logic resvTx_next;
  logic condTx_reg;
  logic condTx_next;
  logic burstTx_reg;
  logic burstTx_next;
  logic devAck;
  logic devInhibit;
  logic retryLow;
  logic timeout;

  // The memory or card controller, or chip select without external acknowledge, answers from inside the device.
  assign devAck = (accessOwner == bus_term_pkg::OWN_MEMCTL ||
                   accessOwner == bus_term_pkg::OWN_CARD ||
                   (accessOwner == bus_term_pkg::OWN_CHIPSEL &&
                    !chipSelExtAck)); // R2 R3
  assign devInhibit = (accessOwner == bus_term_pkg::OWN_MEMCTL ||
                       accessOwner == bus_term_pkg::OWN_CARD); // R8
  assign retryLow = killLow &&
                    (killPinFn == bus_term_pkg::KILL_FN_RETRY);
  assign timeout  = (mon_reg == bus_term_pkg::MON_W'(
                      bus_term_pkg::MONITOR_CYCLES - 1)); // R5

  logic ackSeen;
  assign ackSeen = devAck ? ctlAckReq : ackLow; // R1 R3

  always_comb begin
    state_next   = state_reg;
    mon_next     = mon_reg;
    resvTx_next  = resvTx_reg;
    condTx_next  = condTx_reg;
    burstTx_next = burstTx_reg;
    case (state_reg)
      bus_term_pkg::ST_IDLE: begin
        mon_next = '0;
        if (txStart && txBusGrant) begin
          resvTx_next  = txReserve || txCondStore; // R9
          condTx_next  = txCondStore;
          burstTx_next = txBurst;
          state_next   = bus_term_pkg::ST_WAIT;
        end
      end
      bus_term_pkg::ST_WAIT: begin
        mon_next = mon_reg + bus_term_pkg::MON_W'(1);
        if (errLow || timeout) begin
          state_next = bus_term_pkg::ST_END; // R6
        end else if (retryLow) begin
          state_next = bus_term_pkg::ST_RETRY; // R11
        end else if (ackSeen) begin
          state_next = bus_term_pkg::ST_END;
        end
      end
      bus_term_pkg::ST_END: begin
        resvTx_next = 1'b0;
        state_next  = bus_term_pkg::ST_IDLE; // R4
      end
      bus_term_pkg::ST_RETRY: begin
        mon_next = '0;
        // Mastership is given up until arbitration is won again.
        if (txBusGrant) begin
          state_next = bus_term_pkg::ST_WAIT; // R11
        end
      end
      default: begin
        state_next = bus_term_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= bus_term_pkg::ST_IDLE;
      mon_reg     <= '0;
      resvTx_reg  <= 1'b0;
      condTx_reg  <= 1'b0;
      burstTx_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      mon_reg     <= mon_next;
      resvTx_reg  <= resvTx_next;
      condTx_reg  <= condTx_next;
      burstTx_reg <= burstTx_next;
    end
  end

  logic waiting;
  assign waiting = (state_reg == bus_term_pkg::ST_WAIT);

  ////////////////////////////////////////////////////////////////////////////
  // Result pulses, registered.
  logic done_reg;
  logic err_reg;
  logic retry_reg;
  logic bdeny_reg;
  logic teaDrive_reg;
  logic done_next;
  logic err_next;
  logic retry_next;
  logic bdeny_next;
  logic teaDrive_next;

  always_comb begin
    err_next      = waiting && (errLow || timeout); // R6
    done_next     = waiting && !err_next && !retryLow && ackSeen; // R6
    retry_next    = waiting && !err_next && retryLow; // R11
    bdeny_next    = done_next && burstTx_reg &&
                    (devInhibit ? ctlBurstInhibit : inhibitLow); // R7 R8
    teaDrive_next = waiting && timeout; // R5
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      done_reg     <= 1'b0;
      err_reg      <= 1'b0;
      retry_reg    <= 1'b0;
      bdeny_reg    <= 1'b0;
      teaDrive_reg <= 1'b0;
    end else begin
      done_reg     <= done_next;
      err_reg      <= err_next;
      retry_reg    <= retry_next;
      bdeny_reg    <= bdeny_next;
      teaDrive_reg <= teaDrive_next;
    end
  end

  assign txDone        = done_reg;
  assign txError       = err_reg;
  assign txRetry       = retry_reg;
  assign txBurstDenied = bdeny_reg;
  assign busRelease    = retry_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Reservation flag: set by a reserve load, cleared by kill, cancel or a completed conditional store.
  logic resv_reg;
  logic resv_next;
  logic lost_reg;
  logic lost_next;
  logic killEvt;
  logic cancelEvt;

  assign killEvt   = waiting && condTx_reg && killLow &&
                     (killPinFn == bus_term_pkg::KILL_FN_KILL); // R10
  assign cancelEvt = cancelLow && !cancelPinIsIrq; // R12

  always_comb begin
    resv_next = resv_reg;
    lost_next = killEvt || cancelEvt;
    if (killEvt || cancelEvt) begin
      resv_next = 1'b0; // R10 R12
    end
    if (done_next && resvTx_reg && !condTx_reg) begin
      resv_next = 1'b1;
    end else if (done_next && condTx_reg) begin
      resv_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      resv_reg <= 1'b0;
      lost_reg <= 1'b0;
    end else begin
      resv_reg <= resv_next;
      lost_reg <= lost_next;
    end
  end

  assign reservationHeld = resv_reg;
  assign reservationLost = lost_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Shared interrupt inputs; a pin not in interrupt mode counts as high.
  logic irqTwo_reg;
  logic irqThree_reg;
  logic irqFour_reg;
  logic lineThree;
  logic lineFour;

  always_comb begin
    lineThree = (cancelPinIsIrq ? !cancelLow : 1'b1) &
                (parityZeroIsIrq ? parZero : 1'b1); // R14
    lineFour = ((killPinFn == bus_term_pkg::KILL_FN_IRQ) ? !killLow : 1'b1) &
               (parityOneIsIrq ? parOne : 1'b1); // R13
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irqTwo_reg   <= 1'b0;
      irqThree_reg <= 1'b0;
      irqFour_reg  <= 1'b0;
    end else begin
      irqTwo_reg   <= resvPinIsIrq && resvPinLow; // R15
      irqThree_reg <= (cancelPinIsIrq || parityZeroIsIrq) && !lineThree; // R14
      irqFour_reg  <= ((killPinFn == bus_term_pkg::KILL_FN_IRQ) ||
                       parityOneIsIrq) && !lineFour; // R13
    end
  end

  assign irqTwoReq   = irqTwo_reg;
  assign irqThreeReq = irqThree_reg;
  assign irqFourReq  = irqFour_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Speaker tone divider; its enable pulse toggles the wave.
  logic [bus_term_pkg::SPK_W-1:0] spk_reg;
  logic [bus_term_pkg::SPK_W-1:0] spk_next;
  logic wave_reg;
  logic wave_next;
  logic spkOn;

  assign spkOn = (killPinFn == bus_term_pkg::KILL_FN_SPEAKER);

  always_comb begin
    spk_next  = '0;
    wave_next = 1'b0;
    if (spkOn) begin
      wave_next = wave_reg;
      spk_next  = spk_reg + bus_term_pkg::SPK_W'(1);
      if (spk_reg == bus_term_pkg::SPK_W'(
            bus_term_pkg::SPK_HALF_CYCLES - 1)) begin
        spk_next  = '0;
        wave_next = !wave_reg; // R16
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      spk_reg  <= '0;
      wave_reg <= 1'b0;
    end else begin
      spk_reg  <= spk_next;
      wave_reg <= wave_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers. Acknowledge and inhibit are driven high for one cycle at
  // the end of the access before release, so the pull-up never has to
  // recover the line alone.
  logic ackDrive_reg;
  logic ackNeg_reg;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ackDrive_reg <= 1'b0;
      ackNeg_reg   <= 1'b0;
    end else begin
      // Only a real completion drives it; an error or retry cycle must not.
      ackDrive_reg <= done_next && devAck; // R2 R6
      ackNeg_reg   <= ackDrive_reg; // R4
    end
  end

  assign transfer_ack_n_out        = !ackDrive_reg; // R2
  assign transfer_ack_n_oe_n       = !(ackDrive_reg || ackNeg_reg); // R3 R4
  assign burst_inhibit_n_out       = !(ackDrive_reg && devInhibit &&
                                       burstTx_reg && ctlBurstInhibit); // R8
  assign burst_inhibit_n_oe_n      = !((ackDrive_reg || ackNeg_reg) &&
                                       devInhibit); // R4 R8
  assign transfer_error_ack_n_out  = 1'b0;
  assign transfer_error_ack_n_oe_n = !teaDrive_reg; // R5
  assign reservation_out_n_out     = !resvTx_reg; // R9
  assign reservation_out_n_oe_n    = resvPinIsIrq ||
                                     !(resvTx_reg && waiting); // R9
  assign speaker_wave_out          = wave_reg; // R16
  assign kill_reservation_n_oe_n   = !spkOn; // R16

endmodule

/* File: test/bus_term_asserts.sv */
`timescale 1ns/10ps
module bus_term_asserts (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rstn,
  // Configuration
  input wire logic [1:0] killPinFn,
  input wire logic [1:0] accessOwner,
  input wire logic       chipSelExtAck,
  // Transfer results
  input wire logic       txDone,
  input wire logic       txError,
  input wire logic       txRetry,
  input wire logic       txBurstDenied,
  input wire logic       busRelease,
  // Pins
  input wire logic       transfer_ack_n_out,
  input wire logic       transfer_ack_n_oe_n,
  input wire logic       transfer_error_ack_n_oe_n,
  input wire logic       burst_inhibit_n_out,
  input wire logic       burst_inhibit_n_oe_n,
  input wire logic       reservation_out_n_out,
  input wire logic       reservation_out_n_oe_n,
  input wire logic       kill_reservation_n_oe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic ownInt;
  logic ownExt;
  assign ownInt = accessOwner == bus_term_pkg::OWN_MEMCTL ||
                  accessOwner == bus_term_pkg::OWN_CARD;
  assign ownExt = accessOwner == bus_term_pkg::OWN_EXTERNAL ||
    accessOwner == bus_term_pkg::OWN_CHIPSEL && chipSelExtAck;
  // Negated for one cycle before letting go avoids a slow rise.
  sequence ackNegate;
    !transfer_ack_n_oe_n && transfer_ack_n_out ##1 transfer_ack_n_oe_n;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  ack_internal_a: assert property (
    txDone && ownInt |-> !transfer_ack_n_oe_n && !transfer_ack_n_out)
    else $error("ack not driven low by internal owner");
  ack_release_a: assert property (
    txDone && !transfer_ack_n_oe_n |=> ackNegate)
    else $error("ack not negated then released");
  ack_external_a: assert property (
    ownExt |-> transfer_ack_n_oe_n)
    else $error("ack driven while slave owns it");
  tea_pulse_a: assert property (
    $fell(transfer_error_ack_n_oe_n) |=> transfer_error_ack_n_oe_n)
    else $error("error ack longer than one cycle");
  tea_error_a: assert property (
    $fell(transfer_error_ack_n_oe_n) |-> ##[0:1] txError)
    else $error("error ack without bus error");
  error_excl_a: assert property (
    txError |-> !txDone)
    else $error("done reported with bus error");
  done_gap_a: assert property (
    txDone |=> !txDone && !txError && !txRetry)
    else $error("result right after done");
  retry_release_a: assert property (
    txRetry |-> busRelease ##1 !busRelease)
    else $error("retry without bus release");
  burst_denied_a: assert property (
    txBurstDenied |-> txDone)
    else $error("burst denial outside done");
  inhibit_drive_a: assert property (
    txBurstDenied && ownInt |-> !burst_inhibit_n_oe_n && !burst_inhibit_n_out)
    else $error("burst inhibit not driven low by internal owner");
  resv_level_a: assert property (
    !reservation_out_n_oe_n |-> !reservation_out_n_out)
    else $error("reservation driven inactive");
  speaker_drive_a: assert property (
    !kill_reservation_n_oe_n |-> killPinFn == bus_term_pkg::KILL_FN_SPEAKER
      || $past(killPinFn) == bus_term_pkg::KILL_FN_SPEAKER)
    else $error("kill pin driven outside speaker mode");
endmodule
bind bus_termination_reservation bus_term_asserts CHK (.*);

/* File: test/bus_slave_model.sv */
`timescale 1ns/10ps
// Slave on the far side. Acknowledge and burst inhibit are pulled up.
module bus_slave_model (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rstn,
  // Control from the bench
  input wire logic       mGo,
  input wire logic       mDeny,
  input wire logic [1:0] mMode,
  // Pins
  output logic           mAckN,
  output logic           mAckOeN,
  output logic           mBiN,
  output logic           mBiOeN,
  output logic           mKillN
);
  int   cnt;
  int   at;
  logic act;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      act <= 1'h0;
    end else if (mGo) begin
      cnt <= 1;
      act <= 1'h1;
    end else if (act) begin
      cnt <= cnt + 1;
      act <= cnt < 20;
    end
  end
  // Mode 0 acks, 1 retries first, 2 kills first, 3 never answers.
  always_comb begin
    at = mMode == 2'h0 ? 4 : 10;
    mKillN = !(act && mMode inside {2'h1, 2'h2} && cnt inside {2, 3});
    mAckOeN = !(act && mMode != 2'h3 && cnt >= at && cnt <= at + 2);
    mAckN = cnt >= at + 2;
    mBiOeN = !(mDeny && !mAckOeN);
    mBiN = mAckN;
  end
endmodule

/* File: test/testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic       ref_clk = 1'h0, rstn = 1'h0, mGo = 1'h0, mDeny = 1'h0;
  logic [1:0] killPinFn = 2'h0, accessOwner = 2'h0, mMode = 2'h0;
  logic       cancelPinIsIrq = 1'h0, resvPinIsIrq = 1'h0;
  logic       parityZeroIsIrq = 1'h0, parityOneIsIrq = 1'h0;
  logic       chipSelExtAck = 1'h0, txStart = 1'h0, txReserve = 1'h0;
  logic       txCondStore = 1'h0, txBurst = 1'h0, txBusGrant = 1'h1;
  logic       ctlAckReq = 1'h0, ctlBurstInhibit = 1'h0;
  logic       cancel_reservation_n = 1'h1, parity_lane_zero = 1'h1;
  logic       parity_lane_one = 1'h1, killTb = 1'h1, resvTb = 1'h1;
  logic       txDone, txError, txRetry, txBurstDenied, busRelease;
  logic       reservationHeld, reservationLost, irqTwoReq, irqThreeReq;
  logic       irqFourReq, transfer_ack_n_out, transfer_ack_n_oe_n;
  logic       transfer_error_ack_n_out, transfer_error_ack_n_oe_n;
  logic       burst_inhibit_n_out, burst_inhibit_n_oe_n;
  logic       reservation_out_n_out, reservation_out_n_oe_n;
  logic       speaker_wave_out, kill_reservation_n_oe_n;
  logic       mAckN, mAckOeN, mBiN, mBiOeN, mKillN;
  int         mismatches = 0, comparisons = 0, lostSeen = 0;
  logic [3:0] expQ[$];
  // Pulled-up lines read high once every driver has let go.
  wire logic transfer_ack_n_in = !transfer_ack_n_oe_n ?
    transfer_ack_n_out : !mAckOeN ? mAckN : 1'h1;
  wire logic transfer_error_ack_n_in = transfer_error_ack_n_oe_n |
    transfer_error_ack_n_out;
  wire logic burst_inhibit_n_in = !burst_inhibit_n_oe_n ?
    burst_inhibit_n_out : !mBiOeN ? mBiN : 1'h1;
  wire logic reservation_out_n_in = reservation_out_n_oe_n ?
    resvTb : reservation_out_n_out;
  wire logic kill_reservation_n_in = kill_reservation_n_oe_n ?
    mKillN & killTb : speaker_wave_out;
  bus_termination_reservation DUT (.*);
  bus_slave_model SLV (.*);
  always #10 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic cmpRes(input logic [3:0] e, input logic [3:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected result: expected %h seen %h", e, g);
    end
  endtask
  task automatic cmpBit(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %b seen %b", n, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Result notes are {error, retry, done, burst denied}.
  always @(negedge ref_clk) begin
    if (reservationLost === 1'h1)
      lostSeen++;
    if ((txDone | txError | txRetry) === 1'h1)
      cmpRes(expQ.size() ? expQ.pop_front() : 4'h0,
        {txError, txRetry, txDone, txBurstDenied});
  end
  task automatic xfer(input logic [1:0] own, input logic [1:0] md,
      input logic [3:0] ex, input logic res, input logic cs,
      input logic bst);
    int n;
    logic slv;
    @(negedge ref_clk);
    // An outside slave answers only external and chip-select accesses.
    slv = own == bus_term_pkg::OWN_EXTERNAL ||
          own == bus_term_pkg::OWN_CHIPSEL;
    if (md == 2'h1)
      expQ.push_back(4'h4);
    expQ.push_back(ex);
    {accessOwner, mMode, txReserve, txCondStore, txBurst} =
      {own, md, res, cs, bst};
    {ctlBurstInhibit, mDeny, txStart, mGo} = {bst, bst, 1'h1, slv};
    @(negedge ref_clk);
    {txStart, mGo} = 2'h0;
    repeat (2) @(negedge ref_clk);
    // Raised for every owner; a slave-owned access must ignore it.
    ctlAckReq = 1'h1;
    n = 0;
    while (expQ.size() != 0 && n < 1100) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 1100)
      mismatches++;
    ctlAckReq = 1'h0;
    repeat (5) @(negedge ref_clk);
    $display("transfer test ended");
  endtask
  initial begin
    #(20 * 70000);
    mismatches++;
    end_of_test;
  end
  initial begin
    logic s;
    logic irqMode;
    int   n;
    void'($urandom(44));
    repeat (20) @(negedge ref_clk);
    rstn = 1'h1;
    xfer(bus_term_pkg::OWN_MEMCTL, 2'h0, 4'h2, 1'h1, 1'h0, 1'h0);
    cmpBit("reservationHeld", 1'h1, reservationHeld);
    xfer(bus_term_pkg::OWN_CARD, 2'h0, 4'h3, 1'h0, 1'h0, 1'h1);
    xfer(bus_term_pkg::OWN_EXTERNAL, 2'h0, 4'h3, 1'h0, 1'h0, 1'h1);
    chipSelExtAck = 1'h1;
    xfer(bus_term_pkg::OWN_CHIPSEL, 2'h0, 4'h2, 1'h0, 1'h0, 1'h0);
    killPinFn = bus_term_pkg::KILL_FN_RETRY;
    xfer(bus_term_pkg::OWN_EXTERNAL, 2'h1, 4'h2, 1'h0, 1'h0, 1'h0);
    killPinFn = bus_term_pkg::KILL_FN_KILL;
    xfer(bus_term_pkg::OWN_EXTERNAL, 2'h2, 4'h2, 1'h0, 1'h1, 1'h0);
    cmpBit("killClears", 1'h0, reservationHeld);
    cmpBit("killLost", 1'h1, lostSeen != 0);
    lostSeen = 0;
    xfer(bus_term_pkg::OWN_CARD, 2'h0, 4'h2, 1'h1, 1'h0, 1'h0);
    cmpBit("resvSet", 1'h1, reservationHeld);
    cancel_reservation_n = 1'h0;
    repeat (6) @(negedge ref_clk);
    cancel_reservation_n = 1'h1;
    cmpBit("cancelClears", 1'h0, reservationHeld);
    cmpBit("cancelLost", 1'h1, lostSeen != 0);
    xfer(bus_term_pkg::OWN_EXTERNAL, 2'h3, 4'h8, 1'h0, 1'h0, 1'h0);
    for (int i = 0; i < 8; i++) begin
      @(negedge ref_clk);
      {cancelPinIsIrq, resvPinIsIrq, parityZeroIsIrq, parityOneIsIrq,
       cancel_reservation_n, parity_lane_zero, parity_lane_one, killTb,
       resvTb, irqMode} = 10'($urandom);
      killPinFn = irqMode ? bus_term_pkg::KILL_FN_IRQ : 2'h0;
      repeat (6) @(negedge ref_clk);
      cmpBit("irqTwoReq", resvPinIsIrq & ~resvTb, irqTwoReq);
      cmpBit("irqThreeReq", ~((~cancelPinIsIrq | cancel_reservation_n) &
        (~parityZeroIsIrq | parity_lane_zero)), irqThreeReq);
      cmpBit("irqFourReq", ~((~irqMode | killTb) &
        (~parityOneIsIrq | parity_lane_one)), irqFourReq);
    end
    $display("interrupt test ended");
    killPinFn = bus_term_pkg::KILL_FN_SPEAKER;
    repeat (3) @(negedge ref_clk);
    cmpBit("speakerDrive", 1'h0, kill_reservation_n_oe_n);
    for (int k = 0; k < 2; k++) begin
      s = speaker_wave_out;
      n = 0;
      while (speaker_wave_out === s && n < 25010) begin
        @(negedge ref_clk);
        n++;
      end
    end
    cmpBit("speakerHalf", 1'h1, n == bus_term_pkg::SPK_HALF_CYCLES);
    $display("speaker test ended");
    end_of_test;
  end
endmodule
